// *** logic/trace_defines.svh ***
`ifndef TRACE_DEFINES_SVH
`define TRACE_DEFINES_SVH

// register byte addresses
`define ADDR_PAIR_GAIN      16'h014D
`define ADDR_RESULT_HIGH    16'h0169
`define ADDR_RESULT_LOW     16'h016A
`define ADDR_SHIFT          16'h016B
`define ADDR_BUF_CTRL       16'h016C
`define ADDR_STATUS         16'h016D

// reset values
`define GAIN_BYTE_RST       8'h3F
`define GAIN_CODE_RST       3'h6
`define SHIFT_RST           5'h08
`define BUF_LEN_RST         2'h3

// field positions
`define BUF_CTRL_LEN_LSB    0
`define STATUS_CAL_BIT      0
`define STATUS_CONV_BIT     1
`define STATUS_WORD_BIT     2

// arithmetic and sequencing constants
`define MIDSCALE            14'h1FFF
`define ADC_MAX             16'h3FFF
`define CAL_LAST            4'h7
`define CAL_AVG_SHIFT       3

// gain byte encodings, 1x to 64x
`define GAIN_1X             8'h09
`define GAIN_2X             8'h12
`define GAIN_4X             8'h1B
`define GAIN_8X             8'h24
`define GAIN_16X            8'h2D
`define GAIN_32X            8'h36
`define GAIN_64X            8'h3F

`endif

// *** logic/trace_pkg.sv ***
`default_nettype none
package trace_pkg;

    typedef enum logic [1:0] {
        CAL_IDLE  = 2'b00,
        CAL_MEAS  = 2'b01,
        CAL_STORE = 2'b11
    } cal_state_type;

    // 0 = 1x ... 6 = 64x
    typedef logic [2:0] gain_code_type;

    typedef logic [1:0] adc_chan_type;

    localparam adc_chan_type TEMP_CHANNEL        = 2'h0;
    localparam adc_chan_type UNUSED_CHANNEL      = 2'h1;
    localparam adc_chan_type SHORTED_CAL_CHANNEL = 2'h2;
    localparam adc_chan_type CURRENT_CHANNEL     = 2'h3;

endpackage : trace_pkg
`default_nettype wire

// *** logic/conductance_table.sv ***
`timescale 1ns/10ps
`default_nettype none

module conductance_table #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 12
) (
    input  wire logic              sys_clk_i,
    input  wire logic              resetn_i,
    input  wire logic              wr_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    output logic      [DATA_W-1:0] rdata_o
);

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // contents are whatever the host loads; no reset on the array
    always_ff @(posedge sys_clk_i) begin
        if (wr_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule : conductance_table

`default_nettype wire

// *** logic/avg_buffer.sv ***
`timescale 1ns/10ps
`default_nettype none

module avg_buffer #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic [1:0]       len_sel_i,
    output logic      [WIDTH-1:0] avg_o,
    output logic                  avg_valid_o
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [3:0]                  fill;
        logic [WIDTH-1:0]            avg;
        logic                        valid;
    } buf_state_type;

    buf_state_type q;
    buf_state_type d;
    logic [3:0]       len_n;
    logic [WIDTH+2:0] sum;

    always_comb begin
        d     = q;
        d.valid = 1'b0;
        len_n = 4'h1 << len_sel_i;
        sum   = '0;
        if (push_i) begin
            d.words = {q.words[DEPTH-2:0], data_i};
            if (q.fill != 4'(DEPTH)) begin
                d.fill = q.fill + 4'h1;
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (i < int'(len_n)) begin
                sum = sum + {3'h0, d.words[i]};
            end
        end
        // output only once the selected window is full
        if (push_i && (d.fill >= len_n)) begin
            d.avg   = WIDTH'(sum >> len_sel_i);
            d.valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign avg_o       = q.avg;
    assign avg_valid_o = q.valid;

endmodule : avg_buffer

`default_nettype wire

// *** logic/trace_current_sense_pipeline.sv ***
`timescale 1ns/10ps
`default_nettype none

`include "trace_defines.svh"

module trace_current_sense_pipeline #(
    parameter int ADC_W   = 14,
    parameter int WORD_W  = 16,
    parameter int BUF_DEP = 8,
    parameter int TBL_AW  = 12,
    parameter int TBL_DW  = 12
) (
    input  wire logic                     sys_clk_i,
    input  wire logic                     resetn_i,
    input  wire logic                     conv_start_i,
    input  wire logic                     cal_start_i,
    output logic                          adc_convert_o,
    output trace_pkg::adc_chan_type       adc_chan_o,
    input  wire logic                     adc_valid_i,
    input  wire logic [ADC_W-1:0]         adc_data_i,
    output trace_pkg::gain_code_type      pga_gain_o,
    input  wire logic [15:0]              reg_addr_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    input  wire logic [7:0]               reg_wdata_i,
    output logic      [7:0]               reg_rdata_o,
    input  wire logic                     tbl_wr_i,
    input  wire logic [TBL_AW-1:0]        tbl_addr_i,
    input  wire logic [TBL_DW-1:0]        tbl_data_i,
    output logic                          cal_busy_o,
    output logic                          word_valid_o,
    output logic      [WORD_W-1:0]        current_word_o
);
    import trace_pkg::*;

    // one registered copy of all state; d is its next value
    typedef struct packed {
        cal_state_type        cal;
        logic [3:0]           cal_cnt;
        logic [ADC_W+2:0]     cal_acc;
        logic [ADC_W:0]       off_pair0;
        logic [ADC_W:0]       off_pair1;
        logic                 cal_prev;
        adc_chan_type         chan;
        logic [7:0]           gain_byte;
        gain_code_type        gain;
        logic [4:0]           shift;
        logic [1:0]           len;
        logic                 diff_vld;
        logic [ADC_W:0]       diff;
        logic [TBL_DW-1:0]    cond;
        logic [WORD_W-1:0]    word;
        logic                 word_vld;
        logic                 word_seen;
        logic [7:0]           low_snap;
        logic [7:0]           rdata;
    } state_type;

    state_type q;
    state_type d;

    logic                  push_cur;
    logic                  push_tmp;
    logic [WORD_W-1:0]     corr_word;
    logic [WORD_W-1:0]     cur_avg;
    logic                  cur_avg_vld;
    logic [WORD_W-1:0]     tmp_avg;
    logic                  tmp_avg_vld;
    logic [TBL_DW-1:0]     tbl_rdata;
    logic [TBL_AW-1:0]     tbl_raddr;
    logic signed [ADC_W+TBL_DW+1:0] product;
    logic signed [ADC_W+TBL_DW+1:0] shifted;
    logic [3:0]            gain_dec;
    logic                  conv_run;
    logic signed [ADC_W+TBL_DW+1:0] diff_ext;
    logic signed [ADC_W+TBL_DW+1:0] cond_ext;

    // returns {valid, code}; unknown bytes leave the amplifier gain unchanged
    function automatic logic [3:0] decode_gain(input logic [7:0] b);
        logic [3:0] r;
        r = 4'h0;
        case (b)
            `GAIN_1X:  r = 4'h8;
            `GAIN_2X:  r = 4'h9;
            `GAIN_4X:  r = 4'hA;
            `GAIN_8X:  r = 4'hB;
            `GAIN_16X: r = 4'hC;
            `GAIN_32X: r = 4'hD;
            `GAIN_64X: r = 4'hE;
            default:   r = 4'h0;
        endcase
        return r;
    endfunction : decode_gain

    // offset removal, clamped to the converter range so the buffers never wrap
    function automatic logic [WORD_W-1:0] remove_offset(input logic [ADC_W-1:0] s,
                                                        input logic [ADC_W:0]   off);
        logic signed [WORD_W+1:0] v;
        logic [WORD_W-1:0]        r;
        v = $signed({4'h0, s}) - $signed({{3{off[ADC_W]}}, off});
        r = WORD_W'(v);
        if (v < 0) begin
            r = '0;
        end else if (v > $signed({2'h0, `ADC_MAX})) begin
            r = `ADC_MAX;
        end
        return r;
    endfunction : remove_offset

    // status bits come from live state, so a read shows the present cycle
    function automatic logic [7:0] status_byte(input logic busy,
                                               input logic conv,
                                               input logic seen);
        logic [7:0] r;
        r                   = 8'h00;
        r[`STATUS_CAL_BIT]  = busy;
        r[`STATUS_CONV_BIT] = conv;
        r[`STATUS_WORD_BIT] = seen;
        return r;
    endfunction : status_byte

    // a trigger held through calibration is honoured again only once idle
    assign conv_run  = conv_start_i && (q.cal == CAL_IDLE);
    assign gain_dec  = decode_gain(reg_wdata_i);

    // operands widened to the product width before the multiply, not after
    assign diff_ext  = $signed({{(TBL_DW+1){q.diff[ADC_W]}}, q.diff});
    assign cond_ext  = $signed({{(ADC_W+2){1'b0}}, q.cond});

    // registered table read: a result uses the word of the previous temperature average
    assign tbl_raddr = tmp_avg[ADC_W-1 -: TBL_AW];

    always_comb begin
        d          = q;
        d.diff_vld = 1'b0;
        d.word_vld = 1'b0;
        push_cur   = 1'b0;
        push_tmp   = 1'b0;
        corr_word  = '0;
        product    = '0;
        shifted    = '0;
        d.cal_prev = cal_start_i;

        // calibration sequence on the shorted channel
        case (q.cal)
            CAL_IDLE: begin
                if (cal_start_i && !q.cal_prev) begin
                    d.cal     = CAL_MEAS;
                    d.cal_cnt = 4'h0;
                    d.cal_acc = '0;
                    d.chan    = SHORTED_CAL_CHANNEL;
                end else if (adc_valid_i && conv_run) begin
                    // alternate temperature and current; channel 1 never selected
                    if (q.chan == CURRENT_CHANNEL) begin
                        corr_word = remove_offset(adc_data_i, q.off_pair1);
                        push_cur  = 1'b1;
                        d.chan    = TEMP_CHANNEL;
                    end else begin
                        // temperature pair offset is never measured and stays zero
                        corr_word = remove_offset(adc_data_i, q.off_pair0);
                        push_tmp  = 1'b1;
                        d.chan    = CURRENT_CHANNEL;
                    end
                end
            end
            CAL_MEAS: begin
                // conversion trigger is ignored here
                // raw samples: the offset being measured must not be removed first
                if (adc_valid_i) begin
                    d.cal_acc = q.cal_acc + {3'h0, adc_data_i};
                    d.cal_cnt = q.cal_cnt + 4'h1;
                    if (q.cal_cnt == `CAL_LAST) begin
                        d.cal = CAL_STORE;
                    end
                end
            end
            CAL_STORE: begin
                // stored relative to mid-scale so the differential zero survives
                d.off_pair1 = {1'b0, q.cal_acc[ADC_W+2:`CAL_AVG_SHIFT]}
                              - {1'b0, `MIDSCALE};
                d.cal  = CAL_IDLE;
                d.chan = TEMP_CHANNEL;
            end
            default: begin
                d.cal  = CAL_IDLE;
                d.chan = TEMP_CHANNEL;
            end
        endcase

        // subtract stage, then multiply stage
        if (cur_avg_vld) begin
            d.diff     = {1'b0, cur_avg[ADC_W-1:0]} - {1'b0, `MIDSCALE};
            d.cond     = tbl_rdata;
            d.diff_vld = 1'b1;
        end
        if (q.diff_vld) begin
            product = diff_ext * cond_ext;
            shifted = product >>> q.shift;
            d.word      = shifted[WORD_W-1:0];
            d.word_vld  = 1'b1;
            // sticky until reset so an empty result differs from a zero one
            d.word_seen = 1'b1;
        end

        // register port
        if (reg_wr_i) begin
            case (reg_addr_i)
                `ADDR_PAIR_GAIN: begin
                    d.gain_byte = reg_wdata_i;
                    if (gain_dec[3]) begin
                        d.gain = gain_dec[2:0];
                    end
                end
                `ADDR_SHIFT: begin
                    d.shift = reg_wdata_i[4:0];
                end
                `ADDR_BUF_CTRL: begin
                    d.len = reg_wdata_i[`BUF_CTRL_LEN_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // reads answer one cycle later from the registered data byte
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_PAIR_GAIN: begin
                    d.rdata = q.gain_byte;
                end
                `ADDR_RESULT_HIGH: begin
                    // low byte frozen so a two-byte read stays coherent
                    d.rdata    = q.word[15:8];
                    d.low_snap = q.word[7:0];
                end
                `ADDR_RESULT_LOW: begin
                    d.rdata = q.low_snap;
                end
                `ADDR_SHIFT: begin
                    d.rdata = {3'h0, q.shift};
                end
                `ADDR_BUF_CTRL: begin
                    d.rdata = {6'h00, q.len};
                end
                `ADDR_STATUS: begin
                    d.rdata = status_byte(q.cal != CAL_IDLE, adc_convert_o, q.word_seen);
                end
                default: begin
                    d.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q           <= '0;
            q.cal       <= CAL_IDLE;
            q.chan      <= TEMP_CHANNEL;
            // gain and shift start at 64x and a divide by 256
            q.gain_byte <= `GAIN_BYTE_RST;
            q.gain      <= `GAIN_CODE_RST;
            q.shift     <= `SHIFT_RST;
            q.len       <= `BUF_LEN_RST;
        end else begin
            q <= d;
        end
    end

    // both buffers share one length setting, since the host has one control
    avg_buffer #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEP)
    ) current_avg_buffer (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .push_i      (push_cur),
        .data_i      (corr_word),
        .len_sel_i   (q.len),
        .avg_o       (cur_avg),
        .avg_valid_o (cur_avg_vld)
    );

    avg_buffer #(
        .WIDTH (WORD_W),
        .DEPTH (BUF_DEP)
    ) temp_avg_buffer (
        .sys_clk_i   (sys_clk_i),
        .resetn_i    (resetn_i),
        .push_i      (push_tmp),
        .data_i      (corr_word),
        .len_sel_i   (q.len),
        .avg_o       (tmp_avg),
        .avg_valid_o (tmp_avg_vld)
    );

    // host fills the 1512..2091 range before trusting results
    conductance_table #(
        .ADDR_W (TBL_AW),
        .DATA_W (TBL_DW)
    ) table_inst (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .wr_i      (tbl_wr_i),
        .waddr_i   (tbl_addr_i),
        .wdata_i   (tbl_data_i),
        .raddr_i   (tbl_raddr),
        .rdata_o   (tbl_rdata)
    );

    // conversion request; calibration owns the converter while it runs
    assign adc_convert_o  = (q.cal == CAL_MEAS) || conv_run;
    assign adc_chan_o     = q.chan;
    assign pga_gain_o     = q.gain;
    assign cal_busy_o     = (q.cal != CAL_IDLE);
    assign reg_rdata_o    = q.rdata;
    assign word_valid_o   = q.word_vld;
    assign current_word_o = q.word;

    logic unused_tmp_vld;
    assign unused_tmp_vld = tmp_avg_vld;

endmodule : trace_current_sense_pipeline

`default_nettype wire

// *** verification/trace_checker_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module trace_checker (
    input wire logic                     sys_clk_i,
    input wire logic                     resetn_i,
    input wire logic                     conv_start_i,
    input wire logic                     cal_start_i,
    input wire logic                     adc_convert_o,
    input wire trace_pkg::adc_chan_type  adc_chan_o,
    input wire trace_pkg::gain_code_type pga_gain_o,
    input wire logic [15:0]              reg_addr_i,
    input wire logic                     reg_wr_i,
    input wire logic                     reg_rd_i,
    input wire logic [7:0]               reg_wdata_i,
    input wire logic [7:0]               reg_rdata_o,
    input wire logic                     cal_busy_o,
    input wire logic                     word_valid_o,
    input wire logic [15:0]              current_word_o
);
    import trace_pkg::*;
    logic [7:0] snap_q;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    function automatic logic gain_ok(input logic [7:0] b);
        return b[7:6] == 2'h0 && b[5:3] == b[2:0] && b[2:0] != 3'h0;
    endfunction : gain_ok
    sequence gain_good_s;
        reg_wr_i && reg_addr_i == 16'h014D && gain_ok(reg_wdata_i);
    endsequence
    sequence gain_bad_s;
        reg_wr_i && reg_addr_i == 16'h014D && !gain_ok(reg_wdata_i);
    endsequence
    sequence hi_rd_s;
        reg_rd_i && reg_addr_i == 16'h0169;
    endsequence
    // low byte must come from the same word as the high byte read
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) snap_q <= 8'h00;
        else if (reg_rd_i && reg_addr_i == 16'h0169) snap_q <= current_word_o[7:0];
    end
    no_chan_one_a: assert property (adc_chan_o != UNUSED_CHANNEL)
        else $error("unused channel selected");
    cal_chan_a: assert property (cal_busy_o |-> adc_chan_o == SHORTED_CAL_CHANNEL)
        else $error("calibration not on shorted channel");
    cal_start_a: assert property ($rose(cal_start_i) && !cal_busy_o |=> cal_busy_o)
        else $error("calibration did not start");
    idle_conv_a: assert property (!cal_busy_o |-> adc_convert_o == conv_start_i)
        else $error("conversion request wrong while idle");
    cal_exit_a: assert property ($fell(cal_busy_o) |-> adc_chan_o == TEMP_CHANNEL)
        else $error("first channel after calibration not temperature");
    gain_set_a: assert property (gain_good_s |=> pga_gain_o == $past(reg_wdata_i[2:0]) - 3'h1)
        else $error("gain byte decoded wrongly");
    gain_keep_a: assert property (gain_bad_s |=> $stable(pga_gain_o))
        else $error("invalid gain byte changed gain");
    word_hold_a: assert property (!word_valid_o |-> $stable(current_word_o))
        else $error("result changed without valid");
    high_read_a: assert property (hi_rd_s |=> reg_rdata_o == 8'($past(current_word_o) >> 8))
        else $error("high result byte wrong");
    low_read_a: assert property (reg_rd_i && reg_addr_i == 16'h016A |=> reg_rdata_o == snap_q)
        else $error("low result byte wrong");
endmodule : trace_checker
bind trace_current_sense_pipeline trace_checker u_chk (
    .sys_clk_i, .resetn_i, .conv_start_i, .cal_start_i, .adc_convert_o, .adc_chan_o,
    .pga_gain_o, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .cal_busy_o, .word_valid_o, .current_word_o
);
`default_nettype wire

// *** verification/adc_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_model (
    input  wire logic                    sys_clk_i,
    input  wire logic                    convert_i,
    input  wire trace_pkg::adc_chan_type chan_i,
    input  wire logic                    slow_i,
    input  wire logic [13:0]             temp_i,
    input  wire logic [13:0]             cur_i,
    input  wire logic [13:0]             cal_i,
    output logic                         valid_o,
    output logic      [13:0]             data_o
);
    import trace_pkg::*;
    int gap;
    initial begin
        valid_o = 1'b0;
        data_o = 14'h0000;
        gap = 0;
    end
    // slow mode spaces samples four cycles apart; idle data toggles so no stale word passes
    always @(negedge sys_clk_i) begin
        #1; // step past the bench's own falling-edge writes to the trigger
        gap = gap + 1;
        if (convert_i && (!slow_i || gap >= 4)) begin
            gap = 0;
            valid_o = 1'b1;
            case (chan_i)
                TEMP_CHANNEL:        data_o = temp_i;
                CURRENT_CHANNEL:     data_o = cur_i;
                SHORTED_CAL_CHANNEL: data_o = cal_i;
                default:             data_o = ~data_o;
            endcase
        end else begin
            valid_o = 1'b0;
            data_o = ~data_o;
        end
    end
endmodule : adc_model
`default_nettype wire

// *** verification/trace_current_sense_pipeline_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module trace_current_sense_pipeline_test;
    import trace_pkg::*;
    logic          sys_clk_i, resetn_i, conv_start_i, cal_start_i, adc_valid_i, slow;
    logic          reg_wr_i, reg_rd_i, tbl_wr_i, adc_convert_o, cal_busy_o, word_valid_o;
    logic [13:0]   adc_data_i, t_val, c_val, k_val;
    logic [15:0]   reg_addr_i, current_word_o;
    logic [7:0]    reg_wdata_i, reg_rdata_o, hi, lo;
    logic [11:0]   tbl_addr_i, tbl_data_i;
    adc_chan_type  adc_chan_o;
    gain_code_type pga_gain_o;
    int            fail_count = 0;
    int            n_checks = 0;

    trace_current_sense_pipeline u_dut (
        .sys_clk_i, .resetn_i, .conv_start_i, .cal_start_i, .adc_convert_o, .adc_chan_o,
        .adc_valid_i, .adc_data_i, .pga_gain_o, .reg_addr_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .tbl_wr_i, .tbl_addr_i, .tbl_data_i, .cal_busy_o,
        .word_valid_o, .current_word_o
    );
    adc_model u_adc (
        .sys_clk_i, .convert_i(adc_convert_o), .chan_i(adc_chan_o), .slow_i(slow),
        .temp_i(t_val), .cur_i(c_val), .cal_i(k_val), .valid_o(adc_valid_i),
        .data_o(adc_data_i)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask : reg_rd

    // linear fill between the two end points of the loaded range
    function automatic logic [11:0] tbl(input int a);
        return 12'(794 + ((a - 1512) * 510) / 579);
    endfunction : tbl

    function automatic logic [15:0] word(input int t, input int c, input int s);
        return 16'(((c - 8191) * int'(tbl(t >> 2))) >>> s);
    endfunction : word

    task automatic t_defaults;
        check(16'(pga_gain_o), 16'h0006);
        reg_rd(16'h014D, hi);
        check(16'(hi), 16'h003F);
        reg_rd(16'h016B, hi);
        check(16'(hi), 16'h0008);
        reg_wr(16'h0169, 8'hAA);
        reg_rd(16'h0169, hi);
        check(16'(hi), 16'h0000);
        reg_rd(16'h0200, hi);
        check(16'(hi), 16'h0000);
        reg_rd(16'h016D, hi);
        check(16'(hi), 16'h0000);
        reg_rd(16'h016C, hi);
        check(16'(hi), 16'h0003);
        reg_wr(16'h016C, 8'h01);
        reg_rd(16'h016C, hi);
        check(16'(hi), 16'h0001);
        reg_wr(16'h016C, 8'h03);
    endtask : t_defaults

    task automatic t_gain;
        for (int i = 1; i <= 7; i++) begin
            reg_wr(16'h014D, 8'(i * 9));
            check(16'(pga_gain_o), 16'(i - 1));
        end
        reg_wr(16'h014D, 8'h10);
        check(16'(pga_gain_o), 16'h0006);
        reg_rd(16'h014D, hi);
        check(16'(hi), 16'h0010);
        reg_wr(16'h014D, 8'h3F);
    endtask : t_gain

    task automatic t_load;
        for (int a = 1512; a <= 2091; a++) begin
            @(negedge sys_clk_i);
            tbl_addr_i = 12'(a);
            tbl_data_i = tbl(a);
            tbl_wr_i = 1'b1;
        end
        @(negedge sys_clk_i);
        tbl_wr_i = 1'b0;
        check(16'(tbl(2091)), 16'd1304);
    endtask : t_load

    // offset o is what calibration should remove from the raw current sample
    task automatic t_conv(input int t, input int c, input int o, input int s, input logic sl);
        t_val = 14'(t);
        c_val = 14'(c);
        slow = sl;
        reg_wr(16'h016B, 8'(s));
        @(negedge sys_clk_i);
        conv_start_i = 1'b1;
        repeat (sl ? 200 : 60) @(negedge sys_clk_i);
        conv_start_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        check(current_word_o, word(t, c - o, s));
        reg_rd(16'h0169, hi);
        reg_rd(16'h016A, lo);
        check({hi, lo}, word(t, c - o, s));
        reg_rd(16'h016D, hi);
        check(16'(hi), 16'h0004);
    endtask : t_conv

    task automatic t_cal;
        int n;
        conv_start_i = 1'b0;
        k_val = 14'd8231;
        @(negedge sys_clk_i);
        cal_start_i = 1'b1;
        @(negedge sys_clk_i);
        cal_start_i = 1'b0;
        check(16'(cal_busy_o), 16'h0001);
        reg_rd(16'h016D, hi);
        check(16'(hi), 16'h0007);
        n = 0;
        while (cal_busy_o && n < 100) begin
            @(negedge sys_clk_i);
            n++;
        end
        check(16'(cal_busy_o), 16'h0000);
        check(16'(adc_chan_o), 16'(TEMP_CHANNEL));
        t_conv(8064, 8531, 40, 8, 1'b0);
    endtask : t_cal

    initial begin
        #200_000;
        fail_count++;
        final_report();
    end

    initial begin
        resetn_i = 1'b0;
        conv_start_i = 1'b0;
        cal_start_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 8'h00;
        tbl_wr_i = 1'b0;
        tbl_addr_i = 12'h000;
        tbl_data_i = 12'h000;
        t_val = 14'h0000;
        c_val = 14'h0000;
        k_val = 14'h0000;
        slow = 1'b0;
        repeat (16) @(negedge sys_clk_i);
        resetn_i = 1'b1;
        t_defaults();
        t_gain();
        t_load();
        t_conv(8064, 8491, 0, 8, 1'b0);
        t_conv(6050, 7991, 0, 6, 1'b1);
        t_conv(8367, 16383, 0, 8, 1'b0);
        t_cal();
        final_report();
    end
endmodule : trace_current_sense_pipeline_test
`default_nettype wire
